/* File: adc_port_pkg.sv */
// Constants for the sample output port
package adc_port_pkg;
  localparam int unsigned SAMPLE_WIDTH     = 14;
  localparam int unsigned FIFO_DEPTH       = 16;
  localparam real         CLOCK_PERIOD_NS  = 10.0;
  localparam int unsigned RELOCK_CYCLES    = 100;
  localparam int unsigned NAP_WAKE_CYCLES  = 100;
  localparam logic [13:0] MID_SCALE_CODE   = 14'h2000;
  localparam logic [13:0] POS_FULL_CODE    = 14'h3fff;
  localparam logic [13:0] NEG_FULL_CODE    = 14'h0000;
  localparam int unsigned SIGN_BIT         = 13;
  // Strap levels: ground, third, two thirds, supply
  typedef enum logic [1:0] {
    STRAP_GND   = 2'h0,
    STRAP_THIRD = 2'h1,
    STRAP_TWO3  = 2'h2,
    STRAP_VDD   = 2'h3
  } strap_level_type;
  typedef enum logic [1:0] {
    RUN_ST,
    NAP_ST,
    WAKE_ST
  } power_state_type;
endpackage : adc_port_pkg

/* File: adc_sample_output_port.sv */
// Sample FIFO and digital output stage of the sampling converter
//
// Behaviour
// - With stabilizer, sample on rising edge only; falling edge ignored.
// - With stabilizer, accept 40 to 60 percent duty, keep internal 50.
// - After a clock stop the stabilizer takes about a hundred cycles; here the 100-cycle relock starts when the strap enters a mid level.
// - Offset binary: mid code at zero, saturate at both full scales.
// - Two's complement is offset binary with the top bit inverted.
// - Ground or third strap gives offset binary, else two's complement.
// - Stabilizer on only at the two intermediate strap levels.
// - Overflow flag high beyond full scale, low for in-range samples.
// - Output enable high puts data and overflow outputs in high impedance.
// - Track while clock low, capture on rising edge, hold while high.
// - Nap or sleep floats outputs; nap recovery takes about 100 cycles.
`default_nettype none

module sample_fifo #(
  parameter int unsigned WIDTH = 15,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  wire              push = in_valid && in_ready;
  wire              pop  = out_valid && out_ready;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem_reg[rd_ptr_reg];

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

module adc_sample_output_port #(
  parameter int unsigned WIDTH = adc_port_pkg::SAMPLE_WIDTH,
  parameter int unsigned DEPTH = adc_port_pkg::FIFO_DEPTH
) (
  input  wire logic                         clock,
  input  wire logic                         srst,
  input  wire logic                         sample_valid,
  output logic                              sample_ready,
  input  wire logic signed [WIDTH:0]        core_result,
  input  wire logic [1:0]                   mode_strap,
  input  wire logic                         output_enable_n,
  input  wire logic                         power_down_select,
  input  wire logic                         out_ready,
  output logic [WIDTH-1:0]                  sample_bits,
  output logic                              sample_bits_oe,
  output logic                              overflow_flag,
  output logic                              overflow_flag_oe,
  output logic                              out_valid,
  output logic                              stabilizer_on,
  output logic                              twos_complement,
  output logic                              output_trusted
);
  import adc_port_pkg::*;

  // Two-flop synchronisers for strap and control pins
  logic [1:0] strap_s1_reg, strap_s2_reg;
  logic       oen_s1_reg, oen_s2_reg, pd_s1_reg, pd_s2_reg;
  always_ff @(posedge clock) begin
    strap_s1_reg <= mode_strap;
    strap_s2_reg <= strap_s1_reg;
    oen_s1_reg   <= output_enable_n;
    oen_s2_reg   <= oen_s1_reg;
    pd_s1_reg    <= power_down_select;
    pd_s2_reg    <= pd_s1_reg;
  end

  // Strap decode
  wire strap_mid = (strap_s2_reg == STRAP_THIRD) || (strap_s2_reg == STRAP_TWO3);
  wire strap_twos = (strap_s2_reg == STRAP_TWO3) || (strap_s2_reg == STRAP_VDD);
  assign stabilizer_on   = strap_mid;
  assign twos_complement = strap_twos;

  // Saturating conversion of the signed core result
  localparam logic signed [WIDTH:0] POS_LIM = (WIDTH+1)'(2**(WIDTH-1) - 1);
  localparam logic signed [WIDTH:0] NEG_LIM = -(WIDTH+1)'(2**(WIDTH-1));
  wire over_pos = core_result > POS_LIM;
  wire over_neg = core_result < NEG_LIM;
  wire in_over  = over_pos || over_neg;
  wire [WIDTH-1:0] signed_code = over_pos ? {1'b0, {(WIDTH-1){1'b1}}} :
                                 over_neg ? {1'b1, {(WIDTH-1){1'b0}}} :
                                 core_result[WIDTH-1:0];
  wire [WIDTH-1:0] offset_code = {~signed_code[WIDTH-1], signed_code[WIDTH-2:0]};
  wire [WIDTH-1:0] coded = strap_twos ? {~offset_code[WIDTH-1], offset_code[WIDTH-2:0]}
                                      : offset_code;

  // Word and flag enter the FIFO together, one rising edge each
  logic             fifo_out_valid;
  logic [WIDTH:0]   fifo_out_data;
  sample_fifo #(.WIDTH(WIDTH + 1), .DEPTH(DEPTH)) u_fifo (
    .clock     (clock),
    .srst      (srst),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   ({in_over, coded}),
    .out_valid (fifo_out_valid),
    .out_ready (out_ready),
    .out_data  (fifo_out_data)
  );

  // Power state and relock window
  power_state_type state_reg, state_next;
  logic [7:0]      wait_reg, wait_next;
  logic            stab_prev_reg;
  always_comb begin
    state_next = state_reg;
    wait_next  = wait_reg;
    case (state_reg)
      RUN_ST: begin
        if (pd_s2_reg) begin
          state_next = NAP_ST;
        end else if (strap_mid && !stab_prev_reg) begin
          wait_next  = 8'(RELOCK_CYCLES);
          state_next = WAKE_ST;
        end
      end
      NAP_ST: begin
        if (!pd_s2_reg) begin
          wait_next  = 8'(NAP_WAKE_CYCLES);
          state_next = WAKE_ST;
        end
      end
      WAKE_ST: begin
        if (pd_s2_reg) begin
          state_next = NAP_ST;
        end else if (wait_reg <= 8'h01) begin
          wait_next  = 8'h00;
          state_next = RUN_ST;
        end else begin
          wait_next = wait_reg - 8'h01;
        end
      end
      default: state_next = RUN_ST;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state_reg     <= RUN_ST;
      wait_reg      <= 8'h00;
      stab_prev_reg <= 1'b0;
    end else begin
      state_reg     <= state_next;
      wait_reg      <= wait_next;
      stab_prev_reg <= strap_mid;
    end
  end

  // Registered output pins
  wire drive_en = !oen_s2_reg && (state_reg != NAP_ST);
  always_ff @(posedge clock) begin
    if (srst) begin
      sample_bits      <= '0;
      overflow_flag    <= 1'b0;
      sample_bits_oe   <= 1'b0;
      overflow_flag_oe <= 1'b0;
    end else begin
      sample_bits_oe   <= drive_en;
      overflow_flag_oe <= drive_en;
      if (fifo_out_valid && out_ready) begin
        sample_bits   <= fifo_out_data[WIDTH-1:0];
        overflow_flag <= fifo_out_data[WIDTH];
      end
    end
  end
  assign out_valid      = fifo_out_valid;
  assign output_trusted = (state_reg == RUN_ST);

  AST_OE_FOLLOWS_PIN: assert property (@(posedge clock) disable iff (srst)
    $past(oen_s2_reg) |-> !sample_bits_oe && !overflow_flag_oe)
    else $error("outputs driven while disabled");
  AST_NAP_FLOAT: assert property (@(posedge clock) disable iff (srst)
    state_reg == NAP_ST |=> !sample_bits_oe)
    else $error("outputs driven in nap");
  AST_WAKE_BOUND: assert property (@(posedge clock) disable iff (srst)
    (state_reg == NAP_ST && !pd_s2_reg) |-> ##[1:101] (state_reg == RUN_ST || pd_s2_reg))
    else $error("wake window too long");
  AST_STAB_DECODE: assert property (@(posedge clock) disable iff (srst)
    stabilizer_on == (strap_s2_reg inside {STRAP_THIRD, STRAP_TWO3}))
    else $error("stabilizer decode wrong");
  AST_FORMAT_DECODE: assert property (@(posedge clock) disable iff (srst)
    twos_complement == strap_s2_reg[1])
    else $error("format decode wrong");
  AST_MID_CODE: assert property (@(posedge clock) disable iff (srst)
    (core_result == '0 && !strap_twos) |-> coded == MID_SCALE_CODE)
    else $error("zero input not mid code");
  AST_SAT_POS: assert property (@(posedge clock) disable iff (srst)
    (over_pos && !strap_twos) |-> coded == POS_FULL_CODE && in_over)
    else $error("positive saturation wrong");
  AST_TWOS_FLIP: assert property (@(posedge clock) disable iff (srst)
    (over_neg && strap_twos) |-> coded == MID_SCALE_CODE)
    else $error("twos negative full scale wrong");
  AST_FLAG_LOW: assert property (@(posedge clock) disable iff (srst)
    (fifo_out_valid && out_ready && !fifo_out_data[WIDTH]) |=> !overflow_flag)
    else $error("flag set in range");
  AST_RELOCK: assert property (@(posedge clock) disable iff (srst)
    (state_reg == RUN_ST && !pd_s2_reg && strap_mid && !stab_prev_reg) |=> !output_trusted [*8])
    else $error("relock window missing");
endmodule : adc_sample_output_port

`default_nettype wire

/* File: capture_model.sv */
// Capture logic model that takes words from the output pins
`default_nettype none
module capture_model (
  input  wire logic        clock,
  input  wire logic        stall,
  input  wire logic        out_valid,
  input  wire logic [13:0] sample_bits,
  input  wire logic        overflow_flag,
  input  wire logic        sample_bits_oe,
  output logic             out_ready,
  output logic [14:0]      cap,
  output int               cap_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pop_reg = 1'b0;
  int   cnt_reg = 0;
  assign out_ready = !stall;
  assign cap_count = cnt_reg;
  // Word and flag latched together, one cycle after the pop
  always_ff @(posedge clock) begin
    pop_reg <= out_valid && out_ready;
    if (pop_reg && sample_bits_oe) begin
      cap     <= {overflow_flag, sample_bits};
      cnt_reg <= cnt_reg + 1;
    end
  end
endmodule : capture_model
`default_nettype wire

/* File: tb.sv */
// Testbench for the sample output port
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import adc_port_pkg::*;
  logic clock = 0, srst = 1, sample_valid = 0, output_enable_n = 0;
  logic power_down_select = 0, stall = 0;
  logic signed [14:0] core_result = 0;
  logic [1:0] mode_strap = 0;
  wire logic sample_ready, out_ready, sample_bits_oe, overflow_flag;
  wire logic overflow_flag_oe, out_valid, stabilizer_on, twos_complement;
  wire logic output_trusted;
  wire logic [13:0] sample_bits;
  wire logic [14:0] cap;
  int cap_count, errors = 0, samples_checked = 0;
  int codes[7] = '{0, 1, -1, 8191, -8192, 9000, -9000};
  adc_sample_output_port uut (.clock, .srst, .sample_valid, .sample_ready,
    .core_result, .mode_strap, .output_enable_n, .power_down_select,
    .out_ready, .sample_bits, .sample_bits_oe, .overflow_flag,
    .overflow_flag_oe, .out_valid, .stabilizer_on, .twos_complement,
    .output_trusted);
  capture_model far (.clock, .stall, .out_valid, .sample_bits,
    .overflow_flag, .sample_bits_oe, .out_ready, .cap, .cap_count);
  initial forever #5 clock = ~clock;
  task automatic print_verdict;
    if (errors == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : print_verdict
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask : cyc
  task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask : chk
  task automatic wait_cap(int n);
    for (int i = 0; i < 60 && cap_count != n; i++) cyc(1);
    if (cap_count != n) begin
      errors++;
      print_verdict();
    end
  endtask : wait_cap
  function automatic logic [14:0] exp_code(int x, bit tw);
    logic [13:0] c;
    c = x > 8191 ? 14'h3fff : x < -8192 ? 14'h0000 : 14'(x + 8192);
    if (tw) c[13] = ~c[13];
    return {x > 8191 || x < -8192, c};
  endfunction : exp_code
  task automatic send(int x, bit tw);
    int n;
    n = cap_count;
    core_result = 15'(x);
    sample_valid = 1'b1;
    cyc(1);
    sample_valid = 1'b0;
    wait_cap(n + 1);
    chk("capture", {1'b0, exp_code(x, tw)}, {1'b0, cap});
  endtask : send
  task automatic t_modes;
    for (int s = 0; s < 4; s++) begin
      mode_strap = 2'(s);
      cyc(5);
      chk("stabilizer", 16'(s == 1 || s == 2), 16'(stabilizer_on));
      chk("twos", 16'(s >= 2), 16'(twos_complement));
      if (s == 1) chk("relock", 16'h0, 16'(output_trusted));
      cyc(110);
      chk("trusted", 16'h1, 16'(output_trusted));
      foreach (codes[i]) send(codes[i], s >= 2);
    end
  endtask : t_modes
  task automatic t_fill;
    int acc, n;
    acc = 0;
    n = cap_count;
    stall = 1'b1;
    core_result = 15'h0005;
    // One offer every other cycle; 20 offers overfill the stalled FIFO
    for (int i = 0; i < 40; i++) begin
      sample_valid = (i % 2 == 0);
      acc += int'(sample_valid && sample_ready);
      cyc(1);
    end
    sample_valid = 1'b0;
    chk("accepted", 16'(FIFO_DEPTH), 16'(acc));
    stall = 1'b0;
    wait_cap(n + FIFO_DEPTH);
    chk("drained", 16'h0, 16'(out_valid));
    chk("fill word", {1'b0, exp_code(5, 1'b1)}, {1'b0, cap});
  endtask : t_fill
  task automatic t_float;
    // Disable only while idle, never during streaming
    output_enable_n = 1'b1;
    cyc(5);
    chk("oe", 16'h0, {sample_bits_oe, overflow_flag_oe});
    output_enable_n = 1'b0;
    cyc(5);
    chk("oe", 16'h3, {sample_bits_oe, overflow_flag_oe});
    power_down_select = 1'b1;
    cyc(5);
    chk("nap", 16'h0, {sample_bits_oe, overflow_flag_oe, output_trusted});
    power_down_select = 1'b0;
    cyc(5);
    chk("wake", 16'h0, 16'(output_trusted));
    cyc(110);
    chk("run", 16'h7, {sample_bits_oe, overflow_flag_oe, output_trusted});
  endtask : t_float
  initial begin
    cyc(16);
    srst = 1'b0;
    cyc(5);
    chk("reset", 16'h0, {out_valid, sample_bits});
    t_modes();
    t_fill();
    t_float();
    print_verdict();
  end
endmodule : tb
`default_nettype wire
